// ---- design/opc_pkg.sv ----
/*
 Constants for the programming control and status block of a one-time-programmable memory controller.
 Assumes a 32-bit register port addressed with full system byte addresses.
*/
package opc_pkg;
	localparam logic [31:0] OPC_PCTRL_ADDR = 32'h07F40004;
	localparam logic [31:0] OPC_STAT_ADDR = 32'h07F40008;
	localparam logic [31:0] OPC_PCTRL_RESET = 32'h00000000;
	// Program control fields
	localparam int OPC_START_BIT = 15;
	localparam int OPC_RETRY_BIT = 14;
	localparam int OPC_WIDX_MSB = 12;
	localparam int OPC_WIDX_W = 13;
	// Status fields
	localparam int OPC_NWORDS_LSB = 16;
	localparam int OPC_NWORDS_W = 14;
	localparam int OPC_FWORDS_LSB = 8;
	localparam int OPC_FWORDS_W = 4;
	localparam int OPC_RERR_BIT = 7;
	localparam int OPC_AIDLE_BIT = 6;
	localparam int OPC_TERR_BIT = 5;
	localparam int OPC_TIDLE_BIT = 4;
	localparam int OPC_PIDLE_BIT = 0;
	localparam logic OPC_AIDLE_RESET = 1'b1;
	localparam logic OPC_TIDLE_RESET = 1'b1;
	localparam logic OPC_PIDLE_RESET = 1'b1;
	localparam int OPC_DATA_W = 64;
	localparam int OPC_MODE_W = 3;
	typedef enum logic [2:0]
	{
		OPC_STANDBY_MODE = 3'h0,
		OPC_MANUAL_READ_MODE = 3'h1,
		OPC_MANUAL_PROGRAM_MODE = 3'h2,
		OPC_AUTO_READ_MODE = 3'h3,
		OPC_AUTO_PROGRAM_MODE = 3'h4,
		OPC_BLANK_CHECK_TEST = 3'h5,
		OPC_DECODER_TEST = 3'h6,
		OPC_WRITE_TEST = 3'h7
	} opc_mode_t;
	typedef enum logic [1:0]
	{
		OPC_ST_IDLE = 2'h1,
		OPC_ST_PROG = 2'h2
	} opc_state_t;
endpackage : opc_pkg

// ---- design/opc_program_control_status.sv ----
/*
 Programming control and status registers of a one-time-programmable memory controller.
 Assumes the mode register, data words, FIFO and array sit outside; all inputs are synchronous to i_clk_sys.
*/
module opc_program_control_status
	import opc_pkg::*;
#(
	parameter int DATA_W = OPC_DATA_W,
	parameter int WIDX_W = OPC_WIDX_W
)
(
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	input wire logic [OPC_MODE_W-1:0] i_operating_mode_select,
	input wire logic [DATA_W-1:0] i_program_data_words,
	input wire logic [OPC_NWORDS_W-1:0] i_remaining_word_count,
	input wire logic [OPC_FWORDS_W-1:0] i_fifo_fill_count,
	input wire logic i_read_double_error,
	input wire logic i_auto_busy,
	input wire logic i_test_busy,
	input wire logic i_test_failed,
	input wire logic i_prog_done,
	input wire logic [DATA_W-1:0] i_prog_failed_bits,
	output logic o_prog_req,
	output logic [WIDX_W-1:0] o_prog_word_index,
	output logic [DATA_W-1:0] o_prog_bits,
	output logic o_program_idle
);
	typedef struct packed
	{
		opc_state_t state;
		logic program_retry_select;
		logic [WIDX_W-1:0] program_word_index;
		logic [DATA_W-1:0] failed_bits;
		logic read_double_error_flag;
		logic test_failure_flag;
		logic test_busy_seen;
		logic prog_req;
		logic [WIDX_W-1:0] prog_word_index;
		logic [DATA_W-1:0] prog_bits;
		logic [31:0] rdata;
	} opc_regs_t;

	opc_regs_t r_q;
	opc_regs_t r_d;
	opc_mode_t mode;
	logic wr_ctrl;
	logic wr_stat;
	logic start_ok;
	logic auto_idle;
	logic test_idle;
	logic [31:0] ctrl_view;
	logic [31:0] stat_view;

	assign mode = opc_mode_t'(i_operating_mode_select);
	assign wr_ctrl = i_reg_wr && (i_reg_addr == OPC_PCTRL_ADDR);
	assign wr_stat = i_reg_wr && (i_reg_addr == OPC_STAT_ADDR);
	// Start ignored while a word is still in flight, so the array sees one request per attempt
	assign start_ok = wr_ctrl && i_reg_wdata[OPC_START_BIT] && (mode == OPC_MANUAL_PROGRAM_MODE)
		&& (r_q.state == OPC_ST_IDLE);
	assign auto_idle = !(i_auto_busy && ((mode == OPC_AUTO_READ_MODE) || (mode == OPC_AUTO_PROGRAM_MODE)));
	assign test_idle = !(i_test_busy && ((mode == OPC_BLANK_CHECK_TEST) || (mode == OPC_DECODER_TEST)
		|| (mode == OPC_WRITE_TEST)));

	always_comb
	begin
		ctrl_view = 32'h00000000;
		ctrl_view[OPC_RETRY_BIT] = r_q.program_retry_select;
		ctrl_view[OPC_WIDX_MSB:0] = r_q.program_word_index;
		stat_view = 32'h00000000;
		stat_view[OPC_NWORDS_LSB +: OPC_NWORDS_W] = i_remaining_word_count;
		stat_view[OPC_FWORDS_LSB +: OPC_FWORDS_W] = i_fifo_fill_count;
		stat_view[OPC_RERR_BIT] = r_q.read_double_error_flag;
		stat_view[OPC_AIDLE_BIT] = auto_idle;
		stat_view[OPC_TERR_BIT] = r_q.test_failure_flag;
		stat_view[OPC_TIDLE_BIT] = test_idle;
		stat_view[OPC_PIDLE_BIT] = (r_q.state == OPC_ST_IDLE);
	end

	always_comb
	begin
		r_d = r_q;
		r_d.prog_req = 1'b0;
		if (wr_ctrl)
		begin
			r_d.program_retry_select = i_reg_wdata[OPC_RETRY_BIT];
			r_d.program_word_index = i_reg_wdata[OPC_WIDX_MSB:0];
		end
		case (r_q.state)
			OPC_ST_IDLE:
			begin
				if (start_ok)
				begin
					r_d.state = OPC_ST_PROG;
					r_d.prog_req = 1'b1;
					r_d.prog_word_index = i_reg_wdata[OPC_WIDX_MSB:0];
					// Retry relies on software having made an earlier attempt
					if (i_reg_wdata[OPC_RETRY_BIT])
						r_d.prog_bits = i_program_data_words & r_q.failed_bits;
					else
						r_d.prog_bits = i_program_data_words;
				end
			end
			OPC_ST_PROG:
			begin
				if (i_prog_done)
				begin
					r_d.state = OPC_ST_IDLE;
					r_d.failed_bits = i_prog_failed_bits;
				end
			end
			default:
				r_d.state = OPC_ST_IDLE;
		endcase
		// Set beats a same-cycle clear
		if (wr_stat && i_reg_wdata[OPC_RERR_BIT])
			r_d.read_double_error_flag = 1'b0;
		if (i_read_double_error && ((mode == OPC_MANUAL_READ_MODE) || (mode == OPC_AUTO_READ_MODE)))
			r_d.read_double_error_flag = 1'b1;
		r_d.test_busy_seen = !test_idle;
		if (r_q.test_busy_seen && test_idle)
			r_d.test_failure_flag = i_test_failed;
		if (i_reg_rd)
		begin
			if (i_reg_addr == OPC_PCTRL_ADDR)
				r_d.rdata = ctrl_view;
			else if (i_reg_addr == OPC_STAT_ADDR)
				r_d.rdata = stat_view;
			else
				r_d.rdata = 32'h00000000;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			r_q <= '0;
			r_q.state <= OPC_ST_IDLE;
		end
		else
			r_q <= r_d;
	end

	assign o_reg_rdata = r_q.rdata;
	assign o_prog_req = r_q.prog_req;
	assign o_prog_word_index = r_q.prog_word_index;
	assign o_prog_bits = r_q.prog_bits;
	// Idle is the one-hot bit 0 of the state, so the pin comes straight from a flop
	assign o_program_idle = r_q.state[0];

	// Checks
	a_start_launch: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		start_ok |=> o_prog_req && !o_program_idle)
		else $error("start did not launch programming");
	a_start_blocked: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_wr && mode != OPC_MANUAL_PROGRAM_MODE && o_program_idle) |=> !o_prog_req)
		else $error("start launched outside manual program");
	a_first_bits: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(start_ok && !i_reg_wdata[OPC_RETRY_BIT]) |=> o_prog_bits == $past(i_program_data_words))
		else $error("first try bits wrong");
	// Retry mask is the array's last report, never the data itself
	a_retry_bits: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(start_ok && i_reg_wdata[OPC_RETRY_BIT])
		|=> o_prog_bits == ($past(i_program_data_words) & $past(r_q.failed_bits)))
		else $error("retry bits wrong");
	a_fail_record: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_prog_done && !o_program_idle)
		|=> r_q.failed_bits == $past(i_prog_failed_bits))
		else $error("failed bits not recorded");
	a_index_out: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		start_ok |=> o_prog_word_index == $past(i_reg_wdata[OPC_WIDX_MSB:0]))
		else $error("word index wrong");
	a_rerr_set: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_read_double_error && mode == OPC_AUTO_READ_MODE) |=> r_q.read_double_error_flag)
		else $error("read error not flagged");
	a_rerr_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(r_q.read_double_error_flag && !(wr_stat && i_reg_wdata[OPC_RERR_BIT])) |=> r_q.read_double_error_flag)
		else $error("read error cleared without write one");
	a_auto_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR && i_auto_busy && mode == OPC_AUTO_PROGRAM_MODE)
		|=> !o_reg_rdata[OPC_AIDLE_BIT])
		else $error("auto idle not low");
	a_prog_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(!o_program_idle && !i_prog_done) |=> !o_program_idle)
		else $error("program idle rose early");
	a_ctrl_start_rd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_PCTRL_ADDR) |=> !o_reg_rdata[OPC_START_BIT] && o_reg_rdata[31:16] == 16'h0000)
		else $error("start bit read back set");

	// Launch, busy and idle handshake with the array
	a_req_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_prog_req
		|=> !o_prog_req)
		else $error("program request longer than one cycle");
	a_busy_no_start: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		!o_program_idle
		|=> !o_prog_req)
		else $error("request issued while programming");
	a_req_needs_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		o_prog_req
		|-> $past(i_operating_mode_select) == OPC_MANUAL_PROGRAM_MODE)
		else $error("request issued outside manual program");
	a_idle_return: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_prog_done && !o_program_idle)
		|=> o_program_idle)
		else $error("program idle did not return after done");

	// Bits and index held for the array
	// Array may sample them at any cycle up to done
	a_bits_stable: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(!o_program_idle && !o_prog_req)
		|-> $stable(o_prog_bits))
		else $error("program bits changed mid operation");
	a_index_stable: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(!o_program_idle && !o_prog_req)
		|-> $stable(o_prog_word_index))
		else $error("word index changed mid operation");
	a_ctrl_store: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		wr_ctrl
		|=> r_q.program_word_index == $past(i_reg_wdata[OPC_WIDX_MSB:0])
			&& r_q.program_retry_select == $past(i_reg_wdata[OPC_RETRY_BIT]))
		else $error("control fields not stored");

	// Read error flag
	a_rerr_manual: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_read_double_error && mode == OPC_MANUAL_READ_MODE)
		|=> r_q.read_double_error_flag)
		else $error("manual read error not flagged");
	a_rerr_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(!r_q.read_double_error_flag && !i_read_double_error)
		|=> !r_q.read_double_error_flag)
		else $error("read error flag rose without a double error");
	a_rerr_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(wr_stat && i_reg_wdata[OPC_RERR_BIT] && !i_read_double_error)
		|=> !r_q.read_double_error_flag)
		else $error("write of one did not clear read error");

	// Status view
	a_stat_counts: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR)
		|=> o_reg_rdata[OPC_NWORDS_LSB +: OPC_NWORDS_W] == $past(i_remaining_word_count)
			&& o_reg_rdata[OPC_FWORDS_LSB +: OPC_FWORDS_W] == $past(i_fifo_fill_count))
		else $error("status counts wrong");
	a_stat_reserved: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR)
		|=> o_reg_rdata[31:30] == 2'h0 && o_reg_rdata[15:12] == 4'h0 && o_reg_rdata[3:1] == 3'h0)
		else $error("status reserved bits set");
	a_auto_idle_high: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR && !i_auto_busy)
		|=> o_reg_rdata[OPC_AIDLE_BIT])
		else $error("auto idle low while not busy");
	a_test_idle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR && i_test_busy && mode == OPC_DECODER_TEST)
		|=> !o_reg_rdata[OPC_TIDLE_BIT])
		else $error("test idle high while test runs");
	a_test_idle_high: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR && !i_test_busy)
		|=> o_reg_rdata[OPC_TIDLE_BIT])
		else $error("test idle low with no test");
	a_prog_idle_stat: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(i_reg_rd && i_reg_addr == OPC_STAT_ADDR)
		|=> o_reg_rdata[OPC_PIDLE_BIT] == $past(o_program_idle))
		else $error("status program idle disagrees with pin");

	// Test result, meaningful only once the sequence has ended
	a_test_result: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(!test_idle ##1 test_idle)
		|=> r_q.test_failure_flag == $past(i_test_failed))
		else $error("test failure flag not loaded");

	// Scenarios worth reaching
	c_first_try: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		start_ok ##[1:20] i_prog_done);
	c_retry: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		i_prog_done ##[1:20] (start_ok && i_reg_wdata[OPC_RETRY_BIT]));
	c_rerr_clear: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		r_q.read_double_error_flag ##1 !r_q.read_double_error_flag);
	c_test_fail: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		r_q.test_busy_seen && test_idle && i_test_failed);
	c_auto_busy_read: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		i_reg_rd && i_reg_addr == OPC_STAT_ADDR && !auto_idle);
endmodule : opc_program_control_status

// ---- tb/opc_array_model.sv ----
/*
 Behavioural memory array answering word program requests.
 Assumes requests are one-cycle pulses with bits held until done.
*/
module opc_array_model
	import opc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_prog_req,
	input wire logic [OPC_DATA_W-1:0] i_prog_bits,
	input wire logic [3:0] i_delay,
	input wire logic [OPC_DATA_W-1:0] i_fail_mask,
	output logic o_prog_done,
	output logic [OPC_DATA_W-1:0] o_failed_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_prog_done = 1'b0;
		o_failed_bits = '1;
		forever
		begin
			@(posedge i_clk_sys);
			#1;
			if (i_prog_req === 1'b1)
			begin
				repeat (i_delay) @(posedge i_clk_sys);
				#1 o_prog_done = 1'b1;
				o_failed_bits = i_prog_bits & i_fail_mask;
				@(posedge i_clk_sys);
				#1 o_prog_done = 1'b0;
				// Not valid outside done, so scramble
				o_failed_bits = ~o_failed_bits;
			end
		end
	end
endmodule : opc_array_model

// ---- tb/test_otp_program_control_status.sv ----
/*
 Self-checking bench for the program control and status block.
 Assumes the array model above stands in for the memory.
*/
module test_otp_program_control_status
	import opc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, reg_wr, reg_rd, dbl, ab, tbusy, tfail, pdone, preq, pidle;
	logic [31:0] addr, wdata, rdata, q;
	logic [2:0] mode;
	logic [13:0] nw;
	logic [3:0] ff, dly;
	logic [12:0] pidx, ix;
	logic [63:0] data, fbits, pbits, fm, d;
	int fails, check_count, reqs, cyc;
	opc_program_control_status dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_operating_mode_select(mode),
		.i_program_data_words(data), .i_remaining_word_count(nw), .i_fifo_fill_count(ff),
		.i_read_double_error(dbl), .i_auto_busy(ab), .i_test_busy(tbusy), .i_test_failed(tfail),
		.i_prog_done(pdone), .i_prog_failed_bits(fbits), .o_prog_req(preq), .o_prog_word_index(pidx),
		.o_prog_bits(pbits), .o_program_idle(pidle));
	opc_array_model arr (.i_clk_sys(clk), .i_prog_req(preq), .i_prog_bits(pbits), .i_delay(dly),
		.i_fail_mask(fm), .o_prog_done(pdone), .o_failed_bits(fbits));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) reqs += (preq === 1'b1);
	always @(posedge clk)
	begin
		cyc++;
		// Bound covers every wait loop with margin
		if (cyc == 20000)
		begin
			fails++;
			test_done();
		end
	end
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 q = rdata;
	endtask : rd
	task automatic prog(input logic [2:0] m, input logic rt, input logic [63:0] exp);
		int n0;
		mode <= m;
		data <= d;
		dly <= 4'($urandom % 8);
		n0 = reqs;
		wr(OPC_PCTRL_ADDR, {16'h0000, 1'b1, rt, 1'b0, ix});
		#1 chk(pidle, m != 3'h2);
		if (m == 3'h2)
		begin
			chk(pidx, ix);
			chk(pbits, exp);
		end
		// Idle is looked at once settled, never in its own edge's time step
		for (int n = 0; n < 40 && pidle !== 1'b1; n++)
			@(posedge clk) #1;
		chk(pidle, 1'b1);
		rd(OPC_PCTRL_ADDR);
		chk(q, {16'h0000, 1'b0, rt, 1'b0, ix});
		chk(64'(reqs - n0), m == 3'h2);
	endtask : prog
	function automatic logic [31:0] stat_exp(input int m);
		return {2'h0, nw, 4'h0, ff, 1'b0, !(ab && m inside {3, 4}), 1'b0, !(tbusy && m > 4), 4'h1};
	endfunction : stat_exp
	initial
	begin
		{rst_n, reg_wr, reg_rd, dbl, ab, tbusy, tfail, addr, wdata, mode, data, nw, ff, dly, fm} = '0;
		void'($urandom(32'hF9544720));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(OPC_PCTRL_ADDR);
		chk(q, OPC_PCTRL_RESET);
		for (int m = 0; m < 8; m++)
		begin
			mode <= 3'(m);
			nw <= 14'($urandom);
			ff <= 4'($urandom);
			ab <= 1'($urandom) | (m == 4);
			tbusy <= 1'($urandom) | (m == 6);
			rd(OPC_STAT_ADDR);
			chk(q, stat_exp(m));
			dbl <= 1'b1;
			@(posedge clk) dbl <= 1'b0;
			rd(OPC_STAT_ADDR);
			chk(q[7], m == 1 || m == 3);
			wr(OPC_STAT_ADDR, 32'h00000000);
			rd(OPC_STAT_ADDR);
			chk(q[7], m == 1 || m == 3);
			wr(OPC_STAT_ADDR, 32'h00000080);
			rd(OPC_STAT_ADDR);
			chk(q[7], 1'b0);
		end
		for (int f = 1; f >= 0; f--)
		begin
			mode <= OPC_BLANK_CHECK_TEST;
			tbusy <= 1'b1;
			tfail <= 1'(f);
			repeat (3) @(posedge clk);
			tbusy <= 1'b0;
			repeat (3) @(posedge clk);
			rd(OPC_STAT_ADDR);
			chk(q[5], f);
		end
		// Every mode, then index and data at all ones
		for (int m = 0; m < 9; m++)
		begin
			ix = (m == 8) ? 13'h1FFF : 13'($urandom);
			d = (m == 8) ? '1 : {$urandom, $urandom};
			prog(3'(m == 8 ? 2 : m), 1'b0, d);
		end
		fm <= {$urandom, $urandom};
		d = {$urandom, $urandom};
		prog(OPC_MANUAL_PROGRAM_MODE, 1'b0, d);
		prog(OPC_MANUAL_PROGRAM_MODE, 1'b1, d & fm);
		prog(OPC_MANUAL_PROGRAM_MODE, 1'b1, d & fm);
		test_done();
	end
endmodule : test_otp_program_control_status
